// ---- design/rsse_exec.sv ----
// Execution unit for rotate, literal-subtract and low-power entry.
// Assumes a decoder that presents one operation at a time with its
// file operand, and an AXI4-Lite master for the register view.
//
// Contract
// - Right rotate moves the file byte right, old carry into bit 7, bit 0 into carry.
// - Rotate results go to the accumulator when dest is 0, else back to the file.
// - Literal-subtract stores the 8-bit literal minus the accumulator in the accumulator.
// - Literal-subtract sets carry and digit carry on no borrow and updates zero.
// - The low-power instruction stops the oscillator and execution until a wake-up.
// - The low-power instruction clears watchdog and prescaler, sets time-out, clears power-down.
`timescale 1ns/1ps
`default_nettype none
module rsse_exec #(
   parameter int PRESC_W = rsse_pkg::PRESC_W
) (
   // Clock and reset
   input  wire logic                           i_clk_sys,
   input  wire logic                           i_reset,
   // AXI4-Lite slave
   input  wire logic [rsse_pkg::AXI_ADDR_W-1:0] i_s_axi_awaddr,
   input  wire logic                           i_s_axi_awvalid,
   output logic                                o_s_axi_awready,
   input  wire logic [rsse_pkg::AXI_DATA_W-1:0] i_s_axi_wdata,
   input  wire logic [3:0]                     i_s_axi_wstrb,
   input  wire logic                           i_s_axi_wvalid,
   output logic                                o_s_axi_wready,
   output logic [1:0]                          o_s_axi_bresp,
   output logic                                o_s_axi_bvalid,
   input  wire logic                           i_s_axi_bready,
   input  wire logic [rsse_pkg::AXI_ADDR_W-1:0] i_s_axi_araddr,
   input  wire logic                           i_s_axi_arvalid,
   output logic                                o_s_axi_arready,
   output logic [rsse_pkg::AXI_DATA_W-1:0]     o_s_axi_rdata,
   output logic [1:0]                          o_s_axi_rresp,
   output logic                                o_s_axi_rvalid,
   input  wire logic                           i_s_axi_rready,
   // Decoder side
   input  wire logic                           i_exec_valid,
   input  wire rsse_pkg::rsse_op_type          i_exec_op,
   input  wire logic                           i_exec_dest,
   input  wire logic [rsse_pkg::DATA_W-1:0]    i_exec_file_data,
   input  wire logic [rsse_pkg::DATA_W-1:0]    i_exec_literal,
   input  wire logic                           i_wake,
   output logic                                o_exec_ready,
   // Core state
   output logic                                o_file_we,
   output logic [rsse_pkg::DATA_W-1:0]         o_file_wdata,
   output logic [rsse_pkg::DATA_W-1:0]         o_acc,
   output logic                                o_carry,
   output logic                                o_digit_carry_flag,
   output logic                                o_zero,
   output logic                                o_timeout_flag_n,
   output logic                                o_powerdown_flag_n,
   output logic [rsse_pkg::DATA_W-1:0]         o_watchdog_counter,
   output logic                                o_osc_run
);
   import rsse_pkg::*;

   // ********************************************************
   // Declarations
   // ********************************************************
   rsse_state_type         state_r;
   logic [DATA_W-1:0]      acc_r;
   logic                   carry_r;
   logic                   dc_r;
   logic                   zero_r;
   logic                   to_n_r;
   logic                   pwdn_n_r;
   logic [DATA_W-1:0]      wdog_r;
   logic [PRESC_W-1:0]     presc_r;
   logic                   file_we_r;
   logic [DATA_W-1:0]      file_wdata_r;
   logic [DATA_W-1:0]      alu_result;
   logic                   alu_carry;
   logic                   alu_dc;
   logic                   alu_zero;
   logic                   take;
   logic                   is_rot;
   logic                   wdog_wrap;
   logic                   aw_hold_r;
   logic                   w_hold_r;
   logic [AXI_ADDR_W-1:0]  awaddr_r;
   logic [AXI_DATA_W-1:0]  wdata_r;
   logic                   wstrb0_r;
   logic                   bus_wr;
   logic                   bvalid_r;
   logic [1:0]             bresp_r;
   logic                   rvalid_r;
   logic [1:0]             rresp_r;
   logic [AXI_DATA_W-1:0]  rdata_r;

   // ********************************************************
   // Operation acceptance
   // ********************************************************
   assign o_exec_ready = (state_r == RSSE_ST_RUN);
   assign take   = i_exec_valid && o_exec_ready;
   assign is_rot = (i_exec_op == RSSE_OP_ROTL) ||
                   (i_exec_op == RSSE_OP_ROTR);

   rsse_alu u_alu (
      .i_op               (i_exec_op),
      .i_file_data        (i_exec_file_data),
      .i_literal          (i_exec_literal),
      .i_acc              (acc_r),
      .i_carry            (carry_r),
      .o_result           (alu_result),
      .o_carry            (alu_carry),
      .o_digit_carry_flag (alu_dc),
      .o_zero             (alu_zero)
   );

   // ********************************************************
   // Run and sleep
   // ********************************************************
   // Watchdog expiry also ends sleep, as an external wake would
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         state_r <= RSSE_ST_RUN;
      end else begin
         case (state_r)
            RSSE_ST_RUN: begin
               if (take && i_exec_op == RSSE_OP_SLEEP) begin
                  state_r <= RSSE_ST_SLEEP;
               end
            end
            RSSE_ST_SLEEP: begin
               if (i_wake || wdog_wrap) begin
                  state_r <= RSSE_ST_RUN;
               end
            end
            default: begin
               state_r <= RSSE_ST_RUN;
            end
         endcase
      end
   end

   // ********************************************************
   // Watchdog and prescaler
   // ********************************************************
   assign wdog_wrap = (&presc_r) && (&wdog_r);

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         presc_r <= '0;
         wdog_r  <= WDOG_RST;
      end else if (take && i_exec_op == RSSE_OP_SLEEP) begin
         presc_r <= '0;
         wdog_r  <= WDOG_CLR;
      end else begin
         presc_r <= presc_r + 1'b1;
         if (&presc_r) begin
            wdog_r <= wdog_r + 8'h01;
         end
      end
   end

   // ********************************************************
   // Time-out and power-down flags
   // ********************************************************
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         to_n_r   <= TO_RST;
         pwdn_n_r <= PWDN_RST;
      end else if (take && i_exec_op == RSSE_OP_SLEEP) begin
         to_n_r   <= 1'b1;
         pwdn_n_r <= 1'b0;
      end else if (wdog_wrap) begin
         to_n_r <= 1'b0;
      end
   end

   // ********************************************************
   // Accumulator and file write-back
   // ********************************************************
   // Execution beats a bus write landing in the same cycle
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         acc_r <= ACC_RST;
      end else if (take && i_exec_op == RSSE_OP_SUBL) begin
         acc_r <= alu_result;
      end else if (take && is_rot && !i_exec_dest) begin
         acc_r <= alu_result;
      end else if (bus_wr && awaddr_r == ACC_OFF && wstrb0_r) begin
         acc_r <= wdata_r[DATA_W-1:0];
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         file_we_r    <= 1'b0;
         file_wdata_r <= 8'h00;
      end else begin
         file_we_r <= take && is_rot && i_exec_dest;
         if (take && is_rot && i_exec_dest) begin
            file_wdata_r <= alu_result;
         end
      end
   end

   // ********************************************************
   // Arithmetic flags
   // ********************************************************
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         carry_r <= FLAG_RST;
         dc_r    <= FLAG_RST;
         zero_r  <= FLAG_RST;
      end else if (take && i_exec_op == RSSE_OP_SUBL) begin
         carry_r <= alu_carry;
         dc_r    <= alu_dc;
         zero_r  <= alu_zero;
      end else if (take && is_rot) begin
         carry_r <= alu_carry;
      end else if (bus_wr && awaddr_r == STAT_OFF && wstrb0_r) begin
         carry_r <= wdata_r[STAT_CARRY_BIT];
         dc_r    <= wdata_r[STAT_DC_BIT];
         zero_r  <= wdata_r[STAT_ZERO_BIT];
      end
   end

   // ********************************************************
   // AXI4-Lite write
   // ********************************************************
   assign o_s_axi_awready = !aw_hold_r && !bvalid_r;
   assign o_s_axi_wready  = !w_hold_r && !bvalid_r;
   assign bus_wr          = aw_hold_r && w_hold_r && !bvalid_r;

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         aw_hold_r <= 1'b0;
         w_hold_r  <= 1'b0;
         awaddr_r  <= '0;
         wdata_r   <= '0;
         wstrb0_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= RESP_OKAY;
      end else begin
         if (i_s_axi_awvalid && o_s_axi_awready) begin
            aw_hold_r <= 1'b1;
            awaddr_r  <= i_s_axi_awaddr;
         end
         if (i_s_axi_wvalid && o_s_axi_wready) begin
            w_hold_r <= 1'b1;
            wdata_r  <= i_s_axi_wdata;
            wstrb0_r <= i_s_axi_wstrb[0];
         end
         if (bus_wr) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            bresp_r   <= (awaddr_r == ACC_OFF || awaddr_r == STAT_OFF ||
                          awaddr_r == WDOG_OFF) ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_r && i_s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // ********************************************************
   // AXI4-Lite read
   // ********************************************************
   assign o_s_axi_arready = !rvalid_r;

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         rvalid_r <= 1'b0;
         rresp_r  <= RESP_OKAY;
         rdata_r  <= '0;
      end else if (i_s_axi_arvalid && !rvalid_r) begin
         rvalid_r <= 1'b1;
         rresp_r  <= RESP_OKAY;
         rdata_r  <= '0;
         case (i_s_axi_araddr)
            ACC_OFF:  rdata_r[DATA_W-1:0] <= acc_r;
            STAT_OFF: begin
               rdata_r[STAT_CARRY_BIT] <= carry_r;
               rdata_r[STAT_DC_BIT]    <= dc_r;
               rdata_r[STAT_ZERO_BIT]  <= zero_r;
               rdata_r[STAT_PWDN_BIT]  <= pwdn_n_r;
               rdata_r[STAT_TO_BIT]    <= to_n_r;
               rdata_r[STAT_SLEEP_BIT] <= (state_r == RSSE_ST_SLEEP);
            end
            WDOG_OFF: rdata_r[DATA_W-1:0] <= wdog_r;
            default:  rresp_r <= RESP_SLVERR;
         endcase
      end else if (rvalid_r && i_s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // ********************************************************
   // Outputs
   // ********************************************************
   assign o_s_axi_bvalid     = bvalid_r;
   assign o_s_axi_bresp      = bresp_r;
   assign o_s_axi_rvalid     = rvalid_r;
   assign o_s_axi_rresp      = rresp_r;
   assign o_s_axi_rdata      = rdata_r;
   assign o_file_we          = file_we_r;
   assign o_file_wdata       = file_wdata_r;
   assign o_acc              = acc_r;
   assign o_carry            = carry_r;
   assign o_digit_carry_flag = dc_r;
   assign o_zero             = zero_r;
   assign o_timeout_flag_n   = to_n_r;
   assign o_powerdown_flag_n = pwdn_n_r;
   assign o_watchdog_counter = wdog_r;
   assign o_osc_run          = (state_r == RSSE_ST_RUN);

   // ********************************************************
   // Assertions
   // ********************************************************
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);

   property p_rotr;
      take && i_exec_op == RSSE_OP_ROTR && !i_exec_dest |=>
         o_carry == $past(i_exec_file_data[0]) &&
         o_acc == {$past(carry_r), $past(i_exec_file_data[7:1])};
   endproperty
   a_rotr: assert property (p_rotr) else $error("right rotate wrong");

   property p_dest;
      take && is_rot && i_exec_dest |=>
         o_file_we && o_acc == $past(acc_r) ##1
         (o_file_we == $past(take && is_rot && i_exec_dest));
   endproperty
   a_dest: assert property (p_dest) else $error("rotate dest wrong");

   property p_rotl;
      take && i_exec_op == RSSE_OP_ROTL && i_exec_dest |=>
         o_carry == $past(i_exec_file_data[7]) &&
         o_file_wdata == {$past(i_exec_file_data[6:0]), $past(carry_r)};
   endproperty
   a_rotl: assert property (p_rotl) else $error("left rotate wrong");

   property p_sub;
      take && i_exec_op == RSSE_OP_SUBL |=>
         o_acc == 8'($past(i_exec_literal) - $past(acc_r)) && !o_file_we;
   endproperty
   a_sub: assert property (p_sub) else $error("subtract wrong");

   property p_subflags;
      take && i_exec_op == RSSE_OP_SUBL |=>
         o_carry == ($past(i_exec_literal) >= $past(acc_r)) &&
         o_digit_carry_flag ==
            ($past(i_exec_literal[3:0]) >= $past(acc_r[3:0])) &&
         o_zero == (o_acc == 8'h00);
   endproperty
   a_subflags: assert property (p_subflags) else $error("flags wrong");

   property p_sleep;
      take && i_exec_op == RSSE_OP_SLEEP && !i_wake |=>
         !o_osc_run && !o_exec_ready;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep not entered");

   property p_sleep_flags;
      take && i_exec_op == RSSE_OP_SLEEP |=>
         o_watchdog_counter == 8'h00 && o_timeout_flag_n &&
         !o_powerdown_flag_n;
   endproperty
   a_sleep_flags: assert property (p_sleep_flags) else $error("sleep flags");

   property p_sleep_hold;
      !o_exec_ready && !i_wake && !wdog_wrap |=> !o_exec_ready;
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("woke early");
endmodule
`default_nettype wire

// ---- inc/rsse_pkg.sv ----
// Constants and types shared by the execution unit and its ALU slice.
// Assumes a single 20 MHz core clock and an AXI4-Lite register port.
package rsse_pkg;
   // ********************************************************
   // Widths
   // ********************************************************
   localparam int DATA_W     = 8;
   localparam int AXI_ADDR_W = 4;
   localparam int AXI_DATA_W = 32;
   localparam int PRESC_W    = 8;

   // ********************************************************
   // Register offsets (byte addresses)
   // ********************************************************
   localparam logic [AXI_ADDR_W-1:0] ACC_OFF  = 4'h0;
   localparam logic [AXI_ADDR_W-1:0] STAT_OFF = 4'h4;
   localparam logic [AXI_ADDR_W-1:0] WDOG_OFF = 4'h8;

   // ********************************************************
   // Status register fields
   // ********************************************************
   localparam int STAT_CARRY_BIT = 0;
   localparam int STAT_DC_BIT    = 1;
   localparam int STAT_ZERO_BIT  = 2;
   localparam int STAT_PWDN_BIT  = 3;
   localparam int STAT_TO_BIT    = 4;
   localparam int STAT_SLEEP_BIT = 5;

   // ********************************************************
   // Reset values
   // ********************************************************
   localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
   localparam logic [DATA_W-1:0] WDOG_RST = 8'h00;
   localparam logic [DATA_W-1:0] WDOG_CLR = 8'h00;
   localparam logic              FLAG_RST = 1'b0;
   localparam logic              TO_RST   = 1'b1;
   localparam logic              PWDN_RST = 1'b1;

   // ********************************************************
   // Bus responses
   // ********************************************************
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ********************************************************
   // Operations and core states
   // ********************************************************
   typedef enum logic [3:0] {
      RSSE_OP_ROTL  = 4'h1,
      RSSE_OP_ROTR  = 4'h2,
      RSSE_OP_SUBL  = 4'h4,
      RSSE_OP_SLEEP = 4'h8
   } rsse_op_type;

   typedef enum logic [1:0] {
      RSSE_ST_RUN   = 2'h1,
      RSSE_ST_SLEEP = 2'h2
   } rsse_state_type;
endpackage

// ---- design/rsse_alu.sv ----
// Combinational rotate and literal-subtract slice.
// Assumes the caller registers all results.
`timescale 1ns/1ps
`default_nettype none
module rsse_alu (
   // Operation
   input  wire rsse_pkg::rsse_op_type     i_op,
   input  wire logic [rsse_pkg::DATA_W-1:0] i_file_data,
   input  wire logic [rsse_pkg::DATA_W-1:0] i_literal,
   input  wire logic [rsse_pkg::DATA_W-1:0] i_acc,
   input  wire logic                      i_carry,
   // Results
   output logic [rsse_pkg::DATA_W-1:0]    o_result,
   output logic                           o_carry,
   output logic                           o_digit_carry_flag,
   output logic                           o_zero
);
   import rsse_pkg::*;

   // No-borrow test, used for the full byte and the low nibble
   function automatic logic no_borrow(input logic [7:0] a,
                                      input logic [7:0] b);
      no_borrow = (a >= b);
   endfunction

   always_comb begin
      o_result           = i_acc;
      o_carry            = i_carry;
      o_digit_carry_flag = 1'b0;
      case (i_op)
         RSSE_OP_ROTL: begin
            o_result = {i_file_data[DATA_W-2:0], i_carry};
            o_carry  = i_file_data[DATA_W-1];
         end
         RSSE_OP_ROTR: begin
            o_result = {i_carry, i_file_data[DATA_W-1:1]};
            o_carry  = i_file_data[0];
         end
         RSSE_OP_SUBL: begin
            o_result = i_literal - i_acc;
            o_carry  = no_borrow(i_literal, i_acc);
            o_digit_carry_flag =
               no_borrow({4'h0, i_literal[3:0]},
                         {4'h0, i_acc[3:0]});
         end
         default: begin
            o_result = i_acc;
         end
      endcase
      o_zero = (o_result == 8'h00);
   end
endmodule
`default_nettype wire

// ---- dv/rsse_file_model.sv ----
// File register model standing in for the core register file.
// Assumes the bench loads operands and the unit writes results back.
`timescale 1ns/1ps
`default_nettype none
module rsse_file_model (
   // Clock and reset
   input  wire logic       i_clk_sys,
   input  wire logic       i_reset,
   // Bench load and unit write-back
   input  wire logic       i_load,
   input  wire logic [7:0] i_load_val,
   input  wire logic       i_we,
   input  wire logic [7:0] i_wdata,
   // Operand to the unit
   output logic      [7:0] o_data
);
   // Write-back wins so a result is never lost to a load
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_data <= 8'h00;
      end else if (i_we) begin
         o_data <= i_wdata;
      end else if (i_load) begin
         o_data <= i_load_val;
      end
   end
endmodule
`default_nettype wire

// ---- dv/tb_rotate_subtract_sleep_exec.sv ----
// Self-checking bench for the execution unit with a reference model.
// Assumes the file model in dv and a fast watchdog (PRESC_W of 2).
`timescale 1ns/1ps
`default_nettype none
module tb_rotate_subtract_sleep_exec;
   import rsse_pkg::*;
   logic [3:0]  i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wstrb;
   logic [31:0] i_s_axi_wdata, o_s_axi_rdata, rd;
   logic        i_clk_sys, i_reset, i_s_axi_awvalid, i_s_axi_wvalid;
   logic        i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready;
   logic        o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid;
   logic        o_s_axi_arready, o_s_axi_rvalid, i_exec_valid, i_exec_dest;
   logic [1:0]  o_s_axi_bresp, o_s_axi_rresp, rsp;
   logic        i_wake, o_exec_ready, o_file_we, o_carry, o_zero, load;
   logic        o_digit_carry_flag, o_timeout_flag_n, o_powerdown_flag_n;
   logic        o_osc_run;
   logic [7:0]  i_exec_file_data, i_exec_literal, o_file_wdata, o_acc;
   logic [7:0]  o_watchdog_counter, load_val;
   rsse_op_type i_exec_op;
   rsse_op_type ops [3] = '{RSSE_OP_ROTL, RSSE_OP_ROTR, RSSE_OP_SUBL};
   int          error_cnt, checks, cyc, seed;
   int          acc_m, file_m, c_m, dc_m, z_m, slp_m;

   // ************************************************
   // Clock, instances, bus and exec tasks
   // ************************************************
   initial i_clk_sys = 1'b0;
   always #25 i_clk_sys = ~i_clk_sys;

   rsse_exec #(.PRESC_W(2)) i_rsse_exec (
      .i_clk_sys, .i_reset, .i_s_axi_awaddr, .i_s_axi_awvalid,
      .o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid,
      .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready,
      .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata,
      .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready, .i_exec_valid,
      .i_exec_op, .i_exec_dest, .i_exec_file_data, .i_exec_literal, .i_wake,
      .o_exec_ready, .o_file_we, .o_file_wdata, .o_acc, .o_carry,
      .o_digit_carry_flag, .o_zero, .o_timeout_flag_n, .o_powerdown_flag_n,
      .o_watchdog_counter, .o_osc_run);
   rsse_file_model i_rsse_file_model (.i_clk_sys, .i_reset, .i_load(load),
      .i_load_val(load_val), .i_we(o_file_we), .i_wdata(o_file_wdata),
      .o_data(i_exec_file_data));

   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic final_report;
      if (error_cnt == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_clk_sys);
      i_s_axi_awaddr <= a;
      i_s_axi_wdata <= d;
      i_s_axi_awvalid <= 1'b1;
      i_s_axi_wvalid <= 1'b1;
      i_s_axi_bready <= 1'b1;
      do begin
         @(posedge i_clk_sys);
         if (i_s_axi_awvalid && o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
         if (i_s_axi_wvalid && o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
      end while (o_s_axi_bvalid !== 1'b1);
      rsp = o_s_axi_bresp;
      i_s_axi_bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [3:0] a);
      @(posedge i_clk_sys);
      i_s_axi_araddr <= a;
      i_s_axi_arvalid <= 1'b1;
      i_s_axi_rready <= 1'b1;
      do begin
         @(posedge i_clk_sys);
         if (i_s_axi_arvalid && o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
      end while (o_s_axi_rvalid !== 1'b1);
      rd = o_s_axi_rdata;
      rsp = o_s_axi_rresp;
      i_s_axi_rready <= 1'b0;
   endtask

   // Loads a random file operand, offers one op, then checks the model
   task automatic exec(input rsse_op_type op, input logic d,
                       input logic [7:0] k);
      int f, r, kk;
      @(posedge i_clk_sys);
      load <= 1'b1;
      load_val <= 8'($random(seed));
      @(posedge i_clk_sys);
      load <= 1'b0;
      i_exec_valid <= 1'b1;
      i_exec_op <= op;
      i_exec_dest <= d;
      i_exec_literal <= k;
      @(posedge i_clk_sys);
      i_exec_valid <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
      #1;
      kk = k;
      file_m = load_val;
      f = file_m;
      if (slp_m == 0) begin
         case (op)
            RSSE_OP_ROTL: r = ((f << 1) | c_m) & 255;
            RSSE_OP_ROTR: r = (f >> 1) | (c_m << 7);
            default:      r = (kk - acc_m) & 255;
         endcase
         if (op == RSSE_OP_ROTL) c_m = f >> 7;
         if (op == RSSE_OP_ROTR) c_m = f & 1;
         if (op == RSSE_OP_SUBL) begin
            c_m = kk >= acc_m;
            dc_m = (kk % 16) >= (acc_m % 16);
            z_m = r == 0;
         end
         if (op == RSSE_OP_SLEEP) slp_m = 1;
         else if (op == RSSE_OP_SUBL || !d) acc_m = r;
         else file_m = r;
      end
      chk("acc", acc_m, o_acc);
      chk("carry", c_m, o_carry);
      chk("digit carry", dc_m, o_digit_carry_flag);
      chk("zero", z_m, o_zero);
      chk("file", file_m, i_exec_file_data);
   endtask

   // Hang guard well above the expected run of about 1400 cycles
   always @(posedge i_clk_sys) begin
      cyc++;
      if (cyc == 4000) begin
         error_cnt++;
         final_report();
      end
   end

   // ************************************************
   // Main sequence
   // ************************************************
   initial begin
      seed = 32'h6ca0;
      {i_reset, i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata} = '1;
      {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} = '0;
      {i_s_axi_arvalid, i_s_axi_rready, i_exec_valid, i_exec_dest} = '0;
      {i_wake, load, load_val, i_exec_literal} = '0;
      i_s_axi_wstrb = 4'hf;
      i_exec_op = RSSE_OP_ROTL;
      repeat (8) @(posedge i_clk_sys);
      i_reset <= 1'b0;
      axi_rd(STAT_OFF);
      chk("status", 32'h18, rd);
      axi_wr(STAT_OFF, 32'h5);
      {c_m, z_m} = {32'd1, 32'd1};
      axi_rd(STAT_OFF);
      chk("status", 32'h1d, rd);
      i_s_axi_wstrb <= 4'h0;
      axi_wr(ACC_OFF, 32'hff);
      i_s_axi_wstrb <= 4'hf;
      axi_rd(ACC_OFF);
      chk("acc", 32'h0, rd);
      axi_wr(4'hc, 32'h1);
      chk("bresp", RESP_SLVERR, rsp);
      axi_rd(4'hc);
      chk("rresp", RESP_SLVERR, rsp);
      for (int i = 0; i < 60; i++) begin
         if (i % 8 == 7) begin
            axi_wr(ACC_OFF, 32'($random(seed)));
            acc_m = i_s_axi_wdata & 255;
         end
         exec(ops[{$random(seed)} % 3], 1'($random(seed)),
              8'($random(seed)));
      end
      exec(RSSE_OP_SLEEP, 1'b0, 8'h00);
      chk("osc run", 0, o_osc_run);
      chk("ready", 0, o_exec_ready);
      chk("watchdog", 0, o_watchdog_counter);
      chk("timeout", 1, o_timeout_flag_n);
      chk("powerdown", 0, o_powerdown_flag_n);
      axi_rd(STAT_OFF);
      chk("status", 32'h30 | (z_m << 2) | (dc_m << 1) | c_m, rd);
      // Cleared at the sleep edge, one prescaler wrap before this read
      axi_rd(WDOG_OFF);
      chk("watchdog reg", 32'h1, rd);
      exec(RSSE_OP_ROTL, 1'b0, 8'h00);
      @(posedge i_clk_sys);
      i_wake <= 1'b1;
      @(posedge i_clk_sys);
      i_wake <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
      #1;
      slp_m = 0;
      chk("osc run", 1, o_osc_run);
      exec(RSSE_OP_SLEEP, 1'b0, 8'h00);
      repeat (1000) @(posedge i_clk_sys);
      #1;
      chk("osc run", 0, o_osc_run);
      for (int i = 0; i < 100 && o_osc_run !== 1'b1; i++) begin
         @(posedge i_clk_sys);
      end
      #1;
      slp_m = 0;
      chk("osc run", 1, o_osc_run);
      chk("timeout", 0, o_timeout_flag_n);
      exec(RSSE_OP_SUBL, 1'b0, 8'h00);
      final_report();
   end
endmodule
`default_nettype wire
